// file: hdl/vic_source_ctrl.sv
// Per-source trigger, mask and current-source logic of the vectored interrupt controller
`timescale 1ns/10ps

//Contract
//- Internal sources support level and edge modes, no polarity choice.
//- External sources support high, low level and rising, falling edge.
//- Every source enabled or disabled by single command writes.
//- Mask register reads the resulting enable state of every source.
//- A disabled source never influences other sources.
//- Set and clear commands set and clear edge-mode stored interrupts.
//- Set and clear commands leave level-sensitive sources unchanged.
//- Detected edges are latched until cleared by command or vector read.
//- Normal vector read auto-clears the current source.
//- Auto-clear touches only the current source.
//- Fast-forced sources are not auto-cleared by a normal vector read.
//- Fast vector read auto-clears source 0.
//- Pending register shows real activity, masked or not.
//- Status register returns the current source number.
//- Core status shows both processor request line states.
//- Latency depends on trigger programming and internal or external; here internal and external sources share the same two-flop path.
//- Pin multiplexer routing adds no latency to external sources.
//- Thirty-two sources; 0 is fast input, 1 is system peripherals.
//- Each source carries priority 7 highest down to 0 lowest.
//- Ties in highest priority pick the lowest source number.
//- Normal vector read returns the current source's stored vector.
module vic_source_ctrl (
    input  wire logic                                  ref_clk_in,
    input  wire logic                                  srst_in,
    input  wire logic                                  clk_en_in,
    input  wire logic [vic_pkg::NUM_SRC-1:0]           irq_line_in,
    input  wire logic [vic_pkg::NUM_SRC-1:0]           external_src_in,
    input  wire vic_pkg::vic_mode_t [vic_pkg::NUM_SRC-1:0] source_mode_reg_in,
    input  wire logic [vic_pkg::NUM_SRC-1:0][vic_pkg::VEC_W-1:0] source_vector_reg_in,
    input  wire logic [vic_pkg::NUM_SRC-1:0]           fast_force_in,
    input  wire vic_pkg::vic_cmd_t                     cmd_in,
    input  wire logic                                  normal_vector_rd_in,
    input  wire logic                                  fast_vector_rd_in,
    output logic [vic_pkg::VEC_W-1:0]                  normal_vector_reg_out,
    output vic_pkg::vic_status_t                       status_out,
    output logic                                       normal_irq_out_n,
    output logic                                       fast_irq_out_n
);

    // Highest enabled pending source; lowest number wins ties
    function automatic logic [vic_pkg::SRC_ID_W:0] pick_src(
        input logic [vic_pkg::NUM_SRC-1:0]           act,
        input vic_pkg::vic_mode_t [vic_pkg::NUM_SRC-1:0] mode
    );
        logic [vic_pkg::SRC_ID_W-1:0] best;
        logic [vic_pkg::PRIO_W-1:0]   best_p;
        logic                         found;
        best   = vic_pkg::CUR_RST;
        best_p = vic_pkg::PRIO_RST;
        found  = 1'b0;
        for (int i = vic_pkg::NUM_SRC - 1; i >= 1; i--) begin
            if (act[i] && (!found || mode[i].priority_level_field >= best_p)) begin
                found  = 1'b1;
                best   = i[vic_pkg::SRC_ID_W-1:0];
                best_p = mode[i].priority_level_field;
            end
        end
        return {found, best};
    endfunction

    // Two-flop synchronisers for pin-side lines
    logic [vic_pkg::NUM_SRC-1:0] sync1;
    logic [vic_pkg::NUM_SRC-1:0] sync2;
    logic [vic_pkg::NUM_SRC-1:0] prev_line;
    logic [vic_pkg::NUM_SRC-1:0] edge_latch;
    logic [vic_pkg::NUM_SRC-1:0] mask;
    logic [vic_pkg::SRC_ID_W-1:0] current;
    logic [vic_pkg::NUM_SRC-1:0] pending;
    logic [vic_pkg::NUM_SRC-1:0] next_edge_latch;
    logic [vic_pkg::NUM_SRC-1:0] next_mask;
    logic [vic_pkg::SRC_ID_W-1:0] next_current;
    logic [vic_pkg::VEC_W-1:0]   next_vector;
    logic                        next_irq_n;
    logic                        next_fiq_n;
    logic [vic_pkg::NUM_SRC-1:0] is_edge;
    logic [vic_pkg::NUM_SRC-1:0] cond;
    logic [vic_pkg::NUM_SRC-1:0] normal_act;
    logic [vic_pkg::SRC_ID_W:0]  pick;

    always_comb begin
        for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
            is_edge[i] = source_mode_reg_in[i].trigger_type_field == vic_pkg::VIC_TRIG_EDGE_RISE
                      || source_mode_reg_in[i].trigger_type_field == vic_pkg::VIC_TRIG_EDGE_FALL;
            if (!external_src_in[i]) begin
                cond[i] = is_edge[i] ? (sync2[i] && !prev_line[i]) : sync2[i];
            end else begin
                unique case (source_mode_reg_in[i].trigger_type_field)
                    vic_pkg::VIC_TRIG_LEVEL_HIGH: cond[i] = sync2[i];
                    vic_pkg::VIC_TRIG_LEVEL_LOW:  cond[i] = !sync2[i];
                    vic_pkg::VIC_TRIG_EDGE_RISE:  cond[i] = sync2[i] && !prev_line[i];
                    vic_pkg::VIC_TRIG_EDGE_FALL:  cond[i] = !sync2[i] && prev_line[i];
                endcase
            end
            // pending shows activity regardless of mask
            pending[i] = is_edge[i] ? edge_latch[i] : cond[i];
        end
    end

    always_comb begin
        next_mask = (mask | cmd_in.enable_cmd) & ~cmd_in.disable_cmd;
        // masked and fast-forced sources excluded from normal arbitration
        normal_act = pending & mask & ~fast_force_in;
        pick = pick_src(normal_act, source_mode_reg_in);
        next_current = current;
        next_vector  = normal_vector_reg_out;
        if (normal_vector_rd_in) begin
            next_current = pick[vic_pkg::SRC_ID_W-1:0];
            next_vector = source_vector_reg_in[pick[vic_pkg::SRC_ID_W-1:0]];
        end
        next_edge_latch = edge_latch;
        for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
            if (!is_edge[i]) begin
                next_edge_latch[i] = 1'b0;
            end else begin
                if (normal_vector_rd_in && pick[vic_pkg::SRC_ID_W] && i == int'(pick[vic_pkg::SRC_ID_W-1:0])
                    && !fast_force_in[i]) begin
                    next_edge_latch[i] = 1'b0;
                end
                // fast vector read clears source 0
                if (fast_vector_rd_in && i == 0) begin
                    next_edge_latch[i] = 1'b0;
                end
                if (cmd_in.clear_cmd[i]) begin
                    next_edge_latch[i] = 1'b0;
                end
                // edge or set command wins over clear
                if (cond[i] || cmd_in.set_cmd[i]) begin
                    next_edge_latch[i] = 1'b1;
                end
            end
        end
        // source 0 and forced sources drive the fast line
        next_fiq_n = !(|(pending & mask & (fast_force_in | 32'h0000_0001)));
        next_irq_n = !(|(normal_act & 32'hffff_fffe));
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync1                 <= vic_pkg::EXT_MASK_RST;
            sync2                 <= vic_pkg::EXT_MASK_RST;
            prev_line             <= vic_pkg::EXT_MASK_RST;
            edge_latch            <= vic_pkg::EXT_MASK_RST;
            mask                  <= vic_pkg::MASK_RST;
            current               <= vic_pkg::CUR_RST;
            normal_vector_reg_out <= vic_pkg::VEC_RST;
            normal_irq_out_n      <= 1'b1;
            fast_irq_out_n        <= 1'b1;
            status_out            <= '0;
        end else if (clk_en_in) begin
            // fixed two-flop resync, no mux stage
            sync1                 <= irq_line_in;
            sync2                 <= sync1;
            prev_line             <= sync2;
            edge_latch            <= next_edge_latch;
            mask                  <= next_mask;
            current               <= next_current;
            normal_vector_reg_out <= next_vector;
            normal_irq_out_n      <= next_irq_n;
            fast_irq_out_n        <= next_fiq_n;
            status_out.pending_state_reg    <= pending;
            status_out.mask_state_reg       <= next_mask;
            status_out.current_source_reg   <= next_current;
            status_out.core_line_status_reg <= {!next_fiq_n, !next_irq_n};
        end
    end

    // Enable command is reflected in mask next cycle
    property p_enable_mask;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && cmd_in.enable_cmd[2] && !cmd_in.disable_cmd[2]) |=> status_out.mask_state_reg[2];
    endproperty
    a_enable_mask: assert property (p_enable_mask) else $error("enable not in mask");

    property p_disable_mask;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && cmd_in.disable_cmd[3]) |=> !status_out.mask_state_reg[3];
    endproperty
    a_disable_mask: assert property (p_disable_mask) else $error("disable not in mask");

    property p_set_edge;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && cmd_in.set_cmd[4] && is_edge[4]) |=> edge_latch[4];
    endproperty
    a_set_edge: assert property (p_set_edge) else $error("set did not latch");

    property p_level_cmd;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && !is_edge[5]) |=> !edge_latch[5];
    endproperty
    a_level_cmd: assert property (p_level_cmd) else $error("level source latched");

    property p_hold;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && edge_latch[6] && is_edge[6] && !cmd_in.clear_cmd[6] && !normal_vector_rd_in)
            |=> edge_latch[6];
    endproperty
    a_hold: assert property (p_hold) else $error("edge latch lost");

    property p_fiq_clear;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && fast_vector_rd_in && !cond[0] && !cmd_in.set_cmd[0]) |=> !edge_latch[0];
    endproperty
    a_fiq_clear: assert property (p_fiq_clear) else $error("source 0 not cleared");

    property p_current;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in) |=> status_out.current_source_reg == $past(pick[vic_pkg::SRC_ID_W-1:0]);
    endproperty
    a_current: assert property (p_current) else $error("current number mismatch");

    property p_core;
        @(posedge ref_clk_in) disable iff (srst_in)
        clk_en_in |=> status_out.core_line_status_reg == {!fast_irq_out_n, !normal_irq_out_n};
    endproperty
    a_core: assert property (p_core) else $error("core status mismatch");

    property p_fast_line;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && pending[0] && mask[0]) |=> !fast_irq_out_n && status_out.core_line_status_reg[1];
    endproperty
    a_fast_line: assert property (p_fast_line) else $error("source 0 not on fast line");

    property p_no_src0_normal;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in && pick[vic_pkg::SRC_ID_W]) |=> status_out.current_source_reg != 5'h00;
    endproperty
    a_no_src0_normal: assert property (p_no_src0_normal) else $error("source 0 picked as normal");

    property p_masked_quiet;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && (pending & mask & ~fast_force_in & 32'hffff_fffe) == 32'h0000_0000) |=> normal_irq_out_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("normal line raised by masked source");

    property p_autoclear;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in && pick == 6'h27 && !cond[7] && !cmd_in.set_cmd[7]) |=> !edge_latch[7];
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("current source not auto-cleared");

    property p_other_kept;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && edge_latch[8] && is_edge[8] && !cmd_in.clear_cmd[8] && !(normal_vector_rd_in && pick == 6'h28))
            |=> edge_latch[8];
    endproperty
    a_other_kept: assert property (p_other_kept) else $error("non-current source cleared");

    property p_forced_kept;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && edge_latch[9] && is_edge[9] && fast_force_in[9] && !cmd_in.clear_cmd[9]) |=> edge_latch[9];
    endproperty
    a_forced_kept: assert property (p_forced_kept) else $error("forced source auto-cleared");

    property p_pending_masked;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && edge_latch[10] && is_edge[10] && !mask[10]) |=> status_out.pending_state_reg[10];
    endproperty
    a_pending_masked: assert property (p_pending_masked) else $error("masked source hidden in pending");

    property p_tie;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in && normal_act[11] && normal_act[12]
            && source_mode_reg_in[11].priority_level_field == source_mode_reg_in[12].priority_level_field)
            |=> status_out.current_source_reg != 5'h0c;
    endproperty
    a_tie: assert property (p_tie) else $error("tie not won by lower number");

    property p_prio;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in && normal_act[14]
            && source_mode_reg_in[13].priority_level_field < source_mode_reg_in[14].priority_level_field)
            |=> status_out.current_source_reg != 5'h0d;
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority source picked");

    property p_vector;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && normal_vector_rd_in && pick == 6'h2f)
            |=> normal_vector_reg_out == $past(source_vector_reg_in[15]);
    endproperty
    a_vector: assert property (p_vector) else $error("vector of current source wrong");

    property p_ext_low;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && external_src_in[16] && !sync2[16]
            && source_mode_reg_in[16].trigger_type_field == vic_pkg::VIC_TRIG_LEVEL_LOW)
            |=> status_out.pending_state_reg[16];
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("low level source not pending");

    property p_int_level;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && !external_src_in[1] && sync2[1]
            && source_mode_reg_in[1].trigger_type_field == vic_pkg::VIC_TRIG_LEVEL_LOW)
            |=> status_out.pending_state_reg[1];
    endproperty
    a_int_level: assert property (p_int_level) else $error("internal level polarity applied");

    property p_cmd_zero;
        @(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && !cmd_in.enable_cmd[18] && !cmd_in.disable_cmd[18])
            |=> status_out.mask_state_reg[18] == $past(mask[18]);
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("zero command bit changed mask");
endmodule

// file: hdl/vic_pkg.sv
// Package for the interrupt source front end: field layouts, reset values, types
package vic_pkg;
    localparam int unsigned NUM_SRC        = 32;
    localparam int unsigned SRC_ID_W       = 5;
    localparam int unsigned PRIO_W         = 3;
    localparam int unsigned TRIG_W         = 2;
    localparam int unsigned VEC_W          = 32;
    // Number of low sources wired to embedded peripherals (internal)
    localparam int unsigned NUM_INTERNAL   = 2;
    localparam logic [NUM_SRC-1:0] EXT_MASK_RST  = 32'h0000_0000;
    localparam logic [NUM_SRC-1:0] MASK_RST      = 32'h0000_0000;
    localparam logic [VEC_W-1:0]   VEC_RST       = 32'h0000_0000;
    localparam logic [SRC_ID_W-1:0] CUR_RST      = 5'h00;
    localparam logic [PRIO_W-1:0]   PRIO_RST     = 3'h0;

    // Trigger type field encodings
    typedef enum logic [TRIG_W-1:0] {
        VIC_TRIG_LEVEL_HIGH = 2'h0,
        VIC_TRIG_EDGE_RISE  = 2'h1,
        VIC_TRIG_LEVEL_LOW  = 2'h2,
        VIC_TRIG_EDGE_FALL  = 2'h3
    } vic_trig_t;

    // Source mode register image for one source
    typedef struct packed {
        vic_trig_t              trigger_type_field;
        logic [PRIO_W-1:0]      priority_level_field;
    } vic_mode_t;

    // Command strobes, bit n acts on source n
    typedef struct packed {
        logic [NUM_SRC-1:0] enable_cmd;
        logic [NUM_SRC-1:0] disable_cmd;
        logic [NUM_SRC-1:0] set_cmd;
        logic [NUM_SRC-1:0] clear_cmd;
    } vic_cmd_t;

    // Status image seen by software
    typedef struct packed {
        logic [NUM_SRC-1:0]  pending_state_reg;
        logic [NUM_SRC-1:0]  mask_state_reg;
        logic [SRC_ID_W-1:0] current_source_reg;
        logic [1:0]          core_line_status_reg;
    } vic_status_t;
endpackage

// file: tb/vic_periph_model.sv
// Peripheral side model driving the raw source lines
`timescale 1ns/10ps
module vic_periph_model (
    input  wire logic        ref_clk_in,
    input  wire logic [31:0] req_in,
    output logic [31:0]      irq_line_out
);
    // Lines change only after a clock edge, like a peripheral flop
    initial irq_line_out = 32'h0000_0000;
    always @(posedge ref_clk_in) begin
        irq_line_out <= req_in;
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the interrupt source front end
`timescale 1ns/10ps
module testbench;
    logic                            ref_clk_in = 1'b0;
    logic                            srst_in    = 1'b1;
    logic [31:0]                     req = 32'h0000_0000;
    logic [31:0]                     line;
    vic_pkg::vic_mode_t [31:0]       mode = '0;
    logic [31:0][31:0]               vec  = '0;
    logic [31:0]                     ff   = 32'h0000_0000;
    vic_pkg::vic_cmd_t               cmd  = '0;
    logic                            nrd  = 1'b0;
    logic                            frd  = 1'b0;
    logic                            ce   = 1'b1;
    logic [31:0]                     nvec;
    vic_pkg::vic_status_t            st;
    logic                            normal_irq_out_n_n;
    logic                            firq_n;
    logic [31:0]                     m;
    logic [31:0]                     p;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h69549e09;
    int a;
    int w;
    logic [31:0]                     e;
    logic [31:0]                     d;

    always #10 ref_clk_in = ~ref_clk_in;

    vic_periph_model peri (.ref_clk_in(ref_clk_in), .req_in(req), .irq_line_out(line));
    vic_source_ctrl uut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(ce), .irq_line_in(line),
        .external_src_in(32'hffff_fffc), .source_mode_reg_in(mode), .source_vector_reg_in(vec),
        .fast_force_in(ff), .cmd_in(cmd), .normal_vector_rd_in(nrd), .fast_vector_rd_in(frd),
        .normal_vector_reg_out(nvec), .status_out(st), .normal_irq_out_n(normal_irq_out_n_n), .fast_irq_out_n(firq_n));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic cmdp(input logic [31:0] en, ds, se, cl);
        @(posedge ref_clk_in);
        cmd <= {en, ds, se, cl};
        @(posedge ref_clk_in);
        cmd <= '0;
        wt(3);
    endtask

    task automatic rd(input logic fast);
        @(posedge ref_clk_in);
        if (fast) frd <= 1'b1;
        else nrd <= 1'b1;
        @(posedge ref_clk_in);
        nrd <= 1'b0;
        frd <= 1'b0;
        wt(3);
    endtask

    // Highest priority, lowest number among candidates 1..31
    function automatic int pick(input logic [31:0] cand);
        int r = 0;
        for (int i = 31; i >= 1; i--)
            if (cand[i] && (r == 0 || mode[i].priority_level_field >= mode[r].priority_level_field)) r = i;
        return r;
    endfunction

    initial begin
        for (int i = 0; i < 32; i++) vec[i] = $random(seed);
        repeat (20) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        wt(1);
        chk(st.pending_state_reg, 32'h0000_0000);
        chk(st.mask_state_reg, 32'h0000_0000);
        chk(32'(st.current_source_reg), 32'h0000_0000);
        chk(32'(st.core_line_status_reg), 32'h0000_0000);
        chk({firq_n, normal_irq_out_n_n}, 2'h3);
        m = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            e = $random(seed);
            d = (k == 0) ? 32'h0000_0000 : $random(seed);
            m = (m | e) & ~d;
            cmdp(e, d, 32'h0, 32'h0);
            chk(st.mask_state_reg, m);
        end
        // Clock enable low: the command must not land
        @(posedge ref_clk_in);
        ce <= 1'b0;
        cmdp(32'h0, 32'hffff_ffff, 32'h0, 32'h0);
        chk(st.mask_state_reg, m);
        @(posedge ref_clk_in);
        ce <= 1'b1;
        // Source 1 masked: its pending shows without raising the normal line
        cmdp(32'hffff_fffd, 32'h0000_0002, 32'h0, 32'h0);
        chk(st.mask_state_reg, 32'hffff_fffd);
        a = 2 + ($unsigned($random(seed)) % 30);
        // all four trigger kinds on one external source
        for (int t = 0; t < 4; t++) begin
            @(posedge ref_clk_in);
            mode[a] <= '{vic_pkg::vic_trig_t'(t), 3'h1};
            mode[1] <= '{vic_pkg::vic_trig_t'(t), 3'h1};
            req[a] <= 1'b0;
            req[1] <= 1'b0;
            wt(6);
            cmdp(32'h0, 32'h0, 32'h0, (32'h1 << a) | 32'h2);
            @(posedge ref_clk_in);
            req[a] <= 1'b1;
            req[1] <= 1'b1;
            wt(8);
            chk(st.pending_state_reg[a], t < 2);
            chk(st.pending_state_reg[1], 1'b1);
            chk(!normal_irq_out_n_n, t < 2);
            @(posedge ref_clk_in);
            req[a] <= 1'b0;
            req[1] <= 1'b0;
            wt(8);
            chk(st.pending_state_reg[a], t != 0);
            chk(st.pending_state_reg[1], t[0]);
            cmdp(32'h0, 32'h0, (32'h1 << a) | 32'h2, 32'h0);
            chk(st.pending_state_reg[a], t != 0);
            chk(st.pending_state_reg[1], t[0]);
            cmdp(32'h0, 32'h0, 32'h0, (32'h1 << a) | 32'h2);
            chk(st.pending_state_reg[a], t == 2);
            chk(st.pending_state_reg[1], 1'b0);
        end
        @(posedge ref_clk_in);
        for (int i = 0; i < 32; i++)
            mode[i] <= '{vic_pkg::VIC_TRIG_EDGE_RISE, ($random(seed) & 1) ? 3'h7 : 3'h0};
        p = $random(seed) & 32'hffff_fffe;
        ff <= $random(seed) & $random(seed) & p;
        d = $random(seed) & $random(seed);
        m = ~d;
        cmdp(~d, d, p, ~p);
        chk(st.pending_state_reg, p);
        // auto-clear of the current source only
        for (int k = 0; k < 8; k++) begin
            w = pick(p & m & ~ff);
            rd(1'b0);
            chk(nvec, vec[w]);
            chk(32'(st.current_source_reg), 32'(w));
            if (w != 0) p[w] = 1'b0;
            chk(st.pending_state_reg, p);
        end
        @(posedge ref_clk_in);
        ff <= 32'h0000_0000;
        cmdp(32'h0000_0001, 32'h0, 32'h1, 32'hffff_fffe);
        chk({~firq_n, st.core_line_status_reg[1]}, 2'h3);
        rd(1'b1);
        chk(st.pending_state_reg[0], 1'b0);
        chk({firq_n, normal_irq_out_n_n}, 2'h3);
        give_verdict();
    end
endmodule
